// [shared/fsr_defs.svh]
/*
  offsets, field positions, reset values and timing counts of the
  queue status and pipe width register group.
  assumes it is included by bare name after the package is compiled.
*/
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// register offsets on the command-decoded register port
`define FSR_OFS_PIPE3     8'h14
`define FSR_OFS_PIPE4     8'h15
`define FSR_OFS_PIPE5     8'h16
`define FSR_OFS_QSTAT     8'h17

// payload width field
`define FSR_PW_MSB        5
`define FSR_PW_RESET      6'h00
`define FSR_PW_MAX        6'h20

// queue status bit positions
`define FSR_QS_REUSE      6
`define FSR_QS_TX_FULL    5
`define FSR_QS_TX_EMPTY   4
`define FSR_QS_RX_FULL    1
`define FSR_QS_RX_EMPTY   0
`define FSR_QS_RESET      8'h11

// chip enable pulse timing
`define FSR_CLK_NS        25
`define FSR_CE_MIN_NS     10000
`define FSR_CE_MIN_CYC    ((`FSR_CE_MIN_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)

`endif

// [shared/fsr_pkg.sv]
/*
  types shared by the queue status and pipe width register group.
  assumes nothing beyond a SystemVerilog compiler.
*/
package fsr_pkg;

  // one register access from the serial command decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsr_reg_req_t;

  // one-cycle command strobes from the serial command decoder
  typedef struct packed {
    logic reuse_last_payload_cmd;
    logic write_payload;
    logic flush_tx;
  } fsr_tx_cmd_t;

endpackage : fsr_pkg

// [rtl/fsr_reuse_ctl.sv]
/*
  payload reuse flag and chip enable pulse qualifier.
  assumes command strobes come from logic on clk; the chip enable
  arrives from a pin and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.svh"

module fsr_reuse_ctl
  import fsr_pkg::*;
#(
  parameter int CE_MIN_CYC = `FSR_CE_MIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire fsr_tx_cmd_t cmd,
  input  wire logic        primary_transmitter_role,
  input  wire logic        rfce_pin,
  output logic             reuse_q,
  output logic             retransmit_req
);

  // the saturating counter is twelve bits wide
  if (CE_MIN_CYC < 1 || CE_MIN_CYC > 4095) begin : g_bad_ce
    $error("fsr_reuse_ctl: CE_MIN_CYC out of range");
  end

  logic        ce_meta_q;
  logic        ce_sync_q;
  logic [11:0] ce_cnt_q;
  logic [11:0] ce_cnt_d;
  logic        reuse_d;
  wire         ce_done;
  wire         reuse_clr;

  // two stage synchroniser for the chip enable pin
  always_ff @(posedge clk) begin
    ce_meta_q <= rst ? 1'b0 : rfce_pin;
    ce_sync_q <= rst ? 1'b0 : ce_meta_q;
  end

  // set wins over clear should both strobes ever coincide
  assign reuse_clr = cmd.write_payload | cmd.flush_tx;                  // RULE5
  always_comb begin
    reuse_d = reuse_q;
    if (reuse_clr)
      reuse_d = 1'b0;                                                   // RULE5
    if (cmd.reuse_last_payload_cmd)
      reuse_d = 1'b1;                                                   // RULE4
  end

  // counts how long ce has been high; saturates so one pulse per high
  assign ce_done = (ce_cnt_q == 12'(CE_MIN_CYC - 1));
  always_comb begin
    ce_cnt_d = ce_cnt_q;
    if (!ce_sync_q)
      ce_cnt_d = 12'h0000;
    else if (ce_cnt_q != 12'(CE_MIN_CYC))
      ce_cnt_d = ce_cnt_q + 12'h0001;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reuse_q  <= 1'b0;
      ce_cnt_q <= 12'h0000;
    end else begin
      reuse_q  <= reuse_d;
      ce_cnt_q <= ce_cnt_d;
    end
  end

  // retransmit only for a transmitter with reuse armed; a short ce
  // pulse from the host is ignored rather than half-honoured
  assign retransmit_req = ce_done & ce_sync_q & reuse_q                 // RULE6
                        & primary_transmitter_role;                     // RULE7

  reuse_set_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    cmd.reuse_last_payload_cmd |=> reuse_q)
    else $error("reuse flag not set by reuse command");

  reuse_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    (reuse_clr && !cmd.reuse_last_payload_cmd) |=> !reuse_q)
    else $error("reuse flag not cleared by payload write or flush");

  reuse_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    (reuse_q && !reuse_clr) |=> reuse_q)
    else $error("reuse flag dropped without clearing command");

  rtx_role_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    retransmit_req |-> (primary_transmitter_role && reuse_q))
    else $error("retransmit outside transmitter role or reuse");

  rtx_width_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    retransmit_req |-> $past(ce_sync_q, 1) || CE_MIN_CYC == 1)
    else $error("retransmit without sustained chip enable");

  rtx_once_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    retransmit_req |=> !retransmit_req)
    else $error("retransmit lasted more than one cycle");

  reuse_seen_c: cover property (@(posedge clk) disable iff (rst)
    cmd.reuse_last_payload_cmd ##1 reuse_q);
  rtx_seen_c: cover property (@(posedge clk) disable iff (rst)
    retransmit_req);

endmodule : fsr_reuse_ctl
`default_nettype wire

// [rtl/fsr_regs.sv]
/*
  queue status register and receive payload width registers for
  pipes three to five.
  assumes register accesses and command strobes come from a serial
  command decoder on clk; queue levels come from the payload queues
  on clk; the chip enable pin is asynchronous.
  writes to the status offset are dropped.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.svh"

// What this block does
// [RULE1] pipe three six-bit width, reset zero
// [RULE2] pipe four six-bit width in low bits
// [RULE3] pipe five six-bit width in low bits
// [RULE4] reuse command sets status bit six
// [RULE5] payload write or flush clears reuse
// [RULE6] host holds chip enable ten microseconds
// [RULE7] reuse acts only as primary transmitter
// [RULE8] bits five/four: transmit full/empty
// [RULE9] bits one/zero: receive full/empty
// [RULE10] reserved bits written zero, read zero
module fsr_regs
  import fsr_pkg::*;
#(
  parameter int QDEPTH = 3,
  parameter int LVL_W  = 2,
  parameter int CE_MIN_CYC = `FSR_CE_MIN_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire fsr_reg_req_t     req,
  output logic [7:0]            rd_data,
  input  wire fsr_tx_cmd_t      cmd,
  input  wire logic [LVL_W-1:0] tx_level,
  input  wire logic [LVL_W-1:0] rx_level,
  input  wire logic             primary_transmitter_role,
  input  wire logic             rfce_pin,
  output logic [5:0]            pipe_three_payload_width,
  output logic [5:0]            pipe_four_payload_width,
  output logic [5:0]            pipe_five_payload_width,
  output logic                  reuse_active,
  output logic                  retransmit_req
);

  // the full count must be reachable on the level ports
  if (QDEPTH < 1 || QDEPTH >= (1 << LVL_W)) begin : g_bad_depth
    $error("fsr_regs: QDEPTH does not fit LVL_W");
  end

  // full and empty decode, shared by both queues
  function automatic logic [1:0] q_flags(input logic [LVL_W-1:0] lvl);
    q_flags = {lvl == LVL_W'(QDEPTH), lvl == '0};
  endfunction : q_flags

  logic [5:0] pw_q [3];
  logic [5:0] pw_d [3];
  logic [7:0] rd_data_d;
  logic [1:0] tx_f;
  logic [1:0] rx_f;
  logic       reuse_q;
  logic [7:0] qstat;
  wire  [7:0] pw_ofs [3];

  assign pw_ofs[0] = `FSR_OFS_PIPE3;
  assign pw_ofs[1] = `FSR_OFS_PIPE4;
  assign pw_ofs[2] = `FSR_OFS_PIPE5;

  // width registers: only bits 5:0 are kept, so the reserved top
  // bits cannot latch a stray write
  for (genvar i = 0; i < 3; i++) begin : g_pw
    assign pw_d[i] = (req.wr && req.addr == pw_ofs[i])
                   ? req.wdata[`FSR_PW_MSB:0] : pw_q[i];  // RULE1 RULE2 RULE3
    always_ff @(posedge clk) begin
      pw_q[i] <= rst ? `FSR_PW_RESET : pw_d[i];           // RULE1 RULE2 RULE3
    end
  end

  assign pipe_three_payload_width = pw_q[0];             // RULE1
  assign pipe_four_payload_width  = pw_q[1];             // RULE2
  assign pipe_five_payload_width  = pw_q[2];             // RULE3

  // queue status is live; writes to it change nothing
  assign tx_f = q_flags(tx_level);                       // RULE8
  assign rx_f = q_flags(rx_level);                       // RULE9
  assign qstat = {1'b0, reuse_q, tx_f, 2'b00, rx_f};     // RULE4 RULE10

  // read mux; unmapped offsets return zero
  always_comb begin
    rd_data_d = rd_data;
    if (req.rd) begin
      rd_data_d = 8'h00;
      for (int i = 0; i < 3; i++) begin
        if (req.addr == pw_ofs[i])
          rd_data_d = {2'b00, pw_q[i]};                  // RULE10
      end
      if (req.addr == `FSR_OFS_QSTAT)
        rd_data_d = qstat;                               // RULE8 RULE9
    end
  end

  // read data answers on the edge after the strobe and then holds
  always_ff @(posedge clk) begin
    rd_data <= rst ? 8'h00 : rd_data_d;
  end

  // reuse flag and chip enable qualifier
  fsr_reuse_ctl #(
    .CE_MIN_CYC (CE_MIN_CYC)
  ) u_reuse (
    .clk                      (clk),
    .rst                      (rst),
    .cmd                      (cmd),
    .primary_transmitter_role (primary_transmitter_role),
    .rfce_pin                 (rfce_pin),
    .reuse_q                  (reuse_q),
    .retransmit_req           (retransmit_req)
  );

  // the flag itself lives with the chip enable logic
  assign reuse_active = reuse_q;

  // width registers: reset, write, hold and read back
  pw_reset_a: assert property (@(posedge clk) // RULE1
    rst |=> pipe_three_payload_width == `FSR_PW_RESET
         && pipe_four_payload_width  == `FSR_PW_RESET
         && pipe_five_payload_width  == `FSR_PW_RESET)
    else $error("pipe width not zero after reset");

  pw3_write_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    (req.wr && req.addr == `FSR_OFS_PIPE3)
      |=> pipe_three_payload_width == $past(req.wdata[`FSR_PW_MSB:0]))
    else $error("pipe three width write lost");

  pw_write_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    (req.wr && req.addr == `FSR_OFS_PIPE4)
      |=> pipe_four_payload_width == $past(req.wdata[5:0]))
    else $error("pipe four width write lost");

  pw5_write_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    (req.wr && req.addr == `FSR_OFS_PIPE5)
      |=> pipe_five_payload_width == $past(req.wdata[`FSR_PW_MSB:0]))
    else $error("pipe five width write lost");

  pw3_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    !(req.wr && req.addr == `FSR_OFS_PIPE3)
      |=> $stable(pipe_three_payload_width))
    else $error("pipe three width changed without write");

  pw4_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    !(req.wr && req.addr == `FSR_OFS_PIPE4)
      |=> $stable(pipe_four_payload_width))
    else $error("pipe four width changed without write");

  pw_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    !(req.wr && req.addr == `FSR_OFS_PIPE5)
      |=> $stable(pipe_five_payload_width))
    else $error("pipe five width changed without write");

  pw3_read_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    (req.rd && req.addr == `FSR_OFS_PIPE3)
      |=> rd_data == {2'b00, $past(pipe_three_payload_width)})
    else $error("pipe three width read back wrong");

  pw4_read_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    (req.rd && req.addr == `FSR_OFS_PIPE4)
      |=> rd_data == {2'b00, $past(pipe_four_payload_width)})
    else $error("pipe four width read back wrong");

  pw5_read_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    (req.rd && req.addr == `FSR_OFS_PIPE5)
      |=> rd_data == {2'b00, $past(pipe_five_payload_width)})
    else $error("pipe five width read back wrong");

  // status register and the read port
  tx_flags_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (req.rd && req.addr == `FSR_OFS_QSTAT)
      |=> rd_data[`FSR_QS_TX_FULL]  == ($past(tx_level) == LVL_W'(QDEPTH))
       && rd_data[`FSR_QS_TX_EMPTY] == ($past(tx_level) == '0))
    else $error("transmit queue flags wrong");

  rx_flags_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    (req.rd && req.addr == `FSR_OFS_QSTAT)
      |=> rd_data[`FSR_QS_RX_FULL]  == ($past(rx_level) == LVL_W'(QDEPTH))
       && rd_data[`FSR_QS_RX_EMPTY] == ($past(rx_level) == '0))
    else $error("receive queue flags wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    (req.rd && req.addr == `FSR_OFS_QSTAT)
      |=> rd_data[7] == 1'b0 && rd_data[3:2] == 2'b00)
    else $error("queue status reserved bits read nonzero");

  pw_reserved_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    (req.rd && req.addr inside {`FSR_OFS_PIPE3, `FSR_OFS_PIPE4,
                                `FSR_OFS_PIPE5})
      |=> rd_data[7:6] == 2'b00)
    else $error("pipe width reserved bits read nonzero");

  reuse_read_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    (req.rd && req.addr == `FSR_OFS_QSTAT) |=> rd_data[6] == $past(reuse_q))
    else $error("reuse bit not reported");

  unmapped_rd_a: assert property (@(posedge clk) disable iff (rst)
    (req.rd && !(req.addr inside {`FSR_OFS_PIPE3, `FSR_OFS_PIPE4,
                                  `FSR_OFS_PIPE5, `FSR_OFS_QSTAT}))
      |=> rd_data == 8'h00)
    else $error("unmapped offset read nonzero");

  rd_hold_a: assert property (@(posedge clk) disable iff (rst)
    !req.rd |=> $stable(rd_data))
    else $error("read data moved without a read");

  // main scenarios
  qstat_read_c: cover property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `FSR_OFS_QSTAT && tx_level == LVL_W'(QDEPTH));
  rx_full_c: cover property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `FSR_OFS_QSTAT && rx_level == LVL_W'(QDEPTH));
  pw_write_c: cover property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `FSR_OFS_PIPE4 && req.wdata[5:0] == `FSR_PW_MAX);

endmodule : fsr_regs
`default_nettype wire

// [tb/fsr_host.sv]
/*
  host model: register strobes, command pulses and the chip enable pin.
  assumes one clock shared with the register group.
*/
`timescale 1ns/1ps
`default_nettype none

module fsr_host
  import fsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output var fsr_reg_req_t req,
  output var fsr_tx_cmd_t  cmd,
  output logic            rfce_pin
);
  // idle bus and pin from time zero
  initial begin
    req = '0;
    cmd = '0;
    rfce_pin = 1'b0;
  end

  // one-byte write, reserved bits kept clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & 8'h3f};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // one-byte read; data has stood a full cycle when taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rd_data;
  endtask : rd

  // one-cycle command strobe
  task automatic pulse(input fsr_tx_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask : pulse

  // chip enable high for n cycles; short n breaks the minimum on purpose
  task automatic ce(input int n);
    @(posedge clk);
    rfce_pin <= 1'b1;
    repeat (n) @(posedge clk);
    rfce_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : ce
endmodule : fsr_host

`default_nettype wire

// [tb/tb_fsr_regs.sv]
/*
  self-checking bench for the queue status and pipe width registers.
  assumes the host model drives requests; minimum ce width set to 4.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_fsr_regs;
  import fsr_pkg::*;
  logic         clk;
  logic         rst;
  logic [1:0]   tx_level;
  logic [1:0]   rx_level;
  logic         role;
  fsr_reg_req_t req;
  fsr_tx_cmd_t  cmd;
  logic         rfce_pin;
  logic [7:0]   rd_data;
  logic [5:0]   w3;
  logic [5:0]   w4;
  logic [5:0]   w5;
  logic         reuse_active;
  logic         retransmit_req;
  int           failures = 0;
  int           total_checks = 0;
  int           pulses = 0;
  int           cycles = 0;

  fsr_host host (.clk(clk), .rd_data(rd_data), .req(req), .cmd(cmd),
    .rfce_pin(rfce_pin));
  fsr_regs #(.CE_MIN_CYC(4)) dut (.clk(clk), .rst(rst), .req(req),
    .rd_data(rd_data), .cmd(cmd), .tx_level(tx_level),
    .rx_level(rx_level), .primary_transmitter_role(role),
    .rfce_pin(rfce_pin), .pipe_three_payload_width(w3),
    .pipe_four_payload_width(w4), .pipe_five_payload_width(w5),
    .reuse_active(reuse_active), .retransmit_req(retransmit_req));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count retransmit pulses; old value seen, so no race with the edge
  always @(posedge clk) begin
    if (retransmit_req === 1'b1) pulses++;
  end

  // hang guard: the tests need well under 1500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask : rchk

  task automatic t_reset();
    rchk(8'h14, 8'h00);
    rchk(8'h15, 8'h00);
    rchk(8'h16, 8'h00);
    rchk(8'h17, 8'h11);
    $display("test reset done");
  endtask : t_reset

  // boundary widths, then the ports themselves
  task automatic t_width();
    host.wr(8'h14, 8'h01);
    host.wr(8'h15, 8'h20);
    host.wr(8'h16, 8'h1f);
    host.wr(8'h17, 8'h30);
    rchk(8'h14, 8'h01);
    rchk(8'h15, 8'h20);
    rchk(8'h16, 8'h1f);
    check({2'b00, w3}, 8'h01);
    check({2'b00, w4}, 8'h20);
    check({2'b00, w5}, 8'h1f);
    rchk(8'h17, 8'h11);
    $display("test width done");
  endtask : t_width

  // full and empty flags for several fill levels
  task automatic t_queue();
    // each entry: tx level, rx level, expected status byte
    logic [11:0] tbl [4] = '{12'hc21, 12'h312, 12'h600, 12'h900};
    foreach (tbl[i]) begin
      tx_level <= tbl[i][11:10];
      rx_level <= tbl[i][9:8];
      rchk(8'h17, tbl[i][7:0]);
    end
    tx_level <= 2'd0;
    rx_level <= 2'd0;
    $display("test queue done");
  endtask : t_queue

  task automatic t_reuse();
    role <= 1'b1;
    host.pulse('{reuse_last_payload_cmd: 1'b1, default: 1'b0});
    rchk(8'h17, 8'h51);
    host.ce(8);
    check(pulses[7:0], 8'd1);
    host.ce(2);
    check(pulses[7:0], 8'd1);
    role <= 1'b0;
    host.ce(8);
    check(pulses[7:0], 8'd1);
    role <= 1'b1;
    host.pulse('{write_payload: 1'b1, default: 1'b0});
    rchk(8'h17, 8'h11);
    host.ce(8);
    check(pulses[7:0], 8'd1);
    host.pulse('{reuse_last_payload_cmd: 1'b1, default: 1'b0});
    @(posedge clk);
    check({7'd0, reuse_active}, 8'h01);
    host.pulse('{flush_tx: 1'b1, default: 1'b0});
    rchk(8'h17, 8'h11);
    $display("test reuse done");
  endtask : t_reuse

  // reset in mid-run: widths, reuse flag and read data go back
  task automatic t_rerun();
    host.pulse('{reuse_last_payload_cmd: 1'b1, default: 1'b0});
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(rd_data, 8'h00);
    check({2'b00, w3}, 8'h00);
    check({2'b00, w4}, 8'h00);
    check({2'b00, w5}, 8'h00);
    check({7'd0, reuse_active}, 8'h00);
    rchk(8'h15, 8'h00);
    rchk(8'h17, 8'h11);
    $display("test rerun done");
  endtask : t_rerun

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // reset, then the tests in turn
  initial begin
    rst = 1'b1;
    tx_level = 2'd0;
    rx_level = 2'd0;
    role = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_width();
    t_queue();
    t_reuse();
    t_rerun();
    conclude();
  end
endmodule : tb_fsr_regs

`default_nettype wire
